// ---- design/graph_digit_consts.svh ----
// command codes, bar widths and limits for the graph and digit command decoder
// assumes inclusion by bare name from design files
`ifndef GRAPH_DIGIT_CONSTS_SVH
`define GRAPH_DIGIT_CONSTS_SVH
`define CMD_PREFIX 8'hfe
`define CMD_MED_INIT 8'h6d
`define CMD_MED_PLACE 8'h6f
`define CMD_HBAR_INIT 8'h68
`define CMD_HBAR_PLACE 8'h7c
`define CMD_NBAR_INIT 8'h73
`define CMD_WBAR_INIT 8'h76
`define CMD_VBAR_PLACE 8'h3d
`define CMD_OUT_ON 8'h57
`define CMD_OUT_OFF 8'h56
`define CMD_OUT_BOOT 8'hc3
`define NARROW_BAR_PX 8'h02
`define WIDE_BAR_PX 8'h05
`define ROW_MAX 8'h14
`define COL_MAX 8'h04
`define HCOL_MAX 8'h14
`define HROW_MAX 8'h04
`define HLEN_MAX 8'h64
`define VLEN_MAX 8'h20
`define DIGIT_MAX 8'h09
`endif

// ---- design/graph_digit_pkg.sv ----
// types shared by the graph and digit command decoder
// assumes no other package
package graph_digit_pkg;
  typedef enum logic [1:0] {
    BANK_NONE = 2'b00,
    BANK_MEDIUM = 2'b01,
    BANK_HBAR = 2'b10,
    BANK_VBAR = 2'b11
  } bank_t;
  typedef enum logic [2:0] {
    DRAW_NONE = 3'b000,
    DRAW_DIGIT = 3'b001,
    DRAW_HBAR = 3'b010,
    DRAW_VBAR = 3'b011
  } draw_t;
endpackage

// ---- design/cmd_param_count.sv ----
// maps a command code to the number of parameter bytes it carries
// assumes codes from the shared constants header; unknown codes report invalid
`timescale 1ns/10ps
`include "graph_digit_consts.svh"
module cmd_param_count (
  // code in
  input wire logic [7:0] code_i,
  // count out
  output logic [2:0] count_o,
  output logic known_o
);
  assign known_o = (code_i == `CMD_MED_INIT) || (code_i == `CMD_MED_PLACE) ||
                   (code_i == `CMD_HBAR_INIT) || (code_i == `CMD_HBAR_PLACE) ||
                   (code_i == `CMD_NBAR_INIT) || (code_i == `CMD_WBAR_INIT) ||
                   (code_i == `CMD_VBAR_PLACE) || (code_i == `CMD_OUT_ON) ||
                   (code_i == `CMD_OUT_OFF) || (code_i == `CMD_OUT_BOOT);
  assign count_o = (code_i == `CMD_MED_PLACE) ? 3'h3 :
                   (code_i == `CMD_HBAR_PLACE) ? 3'h4 :
                   (code_i == `CMD_VBAR_PLACE) ? 3'h2 :
                   (code_i == `CMD_OUT_BOOT) ? 3'h2 :
                   ((code_i == `CMD_OUT_ON) || (code_i == `CMD_OUT_OFF)) ? 3'h1 : 3'h0;
endmodule // cmd_param_count

// ---- design/graph_digit_cmd.sv ----
// command decoder for medium digits, bar graphs and switched outputs
// assumes bytes arrive one per byte_valid_i pulse, synchronous to clk_i;
// drawing and non-volatile storage are done outside from the pulses issued here
//
// How it works
// - medium digit place: prefix, code, then row, column, digit bytes in order
// - medium digit place draws one numeral two rows tall, one column wide
// - digit is one decimal numeral; row 1..20, column 1..4
// - horizontal bar init loads the horizontal bar bank
// - horizontal bar carries column, row, direction, length; drawn from that cell
// - direction zero grows right, one grows left
// - horizontal bar length in pixels, zero to one hundred
// - horizontal bar column 1..20, row 1..4
// - a new horizontal bar replaces earlier content in its cells
// - narrow bar init loads a bank with two pixel wide bars
// - wide bar init loads a bank with five pixel wide bars
// - vertical bar carries column, length; grows upward from first row
// - vertical bar height zero to thirty-two pixels, column 1..20
// - a new vertical bar replaces earlier vertical bar content
// - output-on with number byte drives that switched output high
// - output-off with number byte drives that switched output low
// - start-up output stores number and state persistently for next power-up
// - start-up state byte one means on, zero means off
// - medium numeral init loads the medium number bank
`timescale 1ns/10ps
`include "graph_digit_consts.svh"
module graph_digit_cmd #(
  parameter int OUT_COUNT = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // command byte stream
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  // start-up output states read from non-volatile memory
  input wire logic nv_ready_i,
  input wire logic [OUT_COUNT-1:0] nv_out_state_i,
  // character bank in use
  output graph_digit_pkg::bank_t bank_o,
  output logic [7:0] bar_width_o,
  output logic bank_load_o,
  // draw request
  output graph_digit_pkg::draw_t draw_o,
  output logic draw_valid_o,
  output logic [7:0] draw_col_o,
  output logic [7:0] draw_row_o,
  output logic [7:0] draw_value_o,
  output logic draw_left_o,
  output logic draw_error_o,
  // switched outputs
  output logic [OUT_COUNT-1:0] switched_output_o,
  // non-volatile store request
  output logic nv_write_o,
  output logic [7:0] nv_number_o,
  output logic nv_state_o,
  // decoder state
  output logic busy_o
);
  typedef enum logic [1:0] {
    ST_PREFIX = 2'b00,
    ST_CODE = 2'b01,
    ST_PARAM = 2'b10
  } state_t;

  state_t state_q;
  state_t state_d;
  logic [7:0] code_q;
  logic [2:0] need_q;
  logic [2:0] got_q;
  logic [7:0] p0_q;
  logic [7:0] p1_q;
  logic [7:0] p2_q;
  logic boot_done_q;
  graph_digit_pkg::bank_t bank_q;
  logic [7:0] bar_width_q;
  logic bank_load_q;
  graph_digit_pkg::draw_t draw_q;
  logic draw_valid_q;
  logic [7:0] draw_col_q;
  logic [7:0] draw_row_q;
  logic [7:0] draw_value_q;
  logic draw_left_q;
  logic draw_error_q;
  logic [OUT_COUNT-1:0] out_q;
  logic nv_write_q;
  logic [7:0] nv_number_q;
  logic nv_state_q;
  logic busy_q;

  wire logic [2:0] param_count;
  wire logic code_known;

  cmd_param_count u_count (
    .code_i(byte_i),
    .count_o(param_count),
    .known_o(code_known)
  );

  // position parameters count from one, so zero is out of range for all of them
  function automatic logic in_range(input logic [7:0] v, input logic [7:0] max);
    in_range = (v >= 8'h01) && (v <= max);
  endfunction

  // a command is complete when its last parameter byte arrives, or at once if it has none
  wire logic take_code = byte_valid_i && (state_q == ST_CODE) && code_known;
  wire logic last_param = byte_valid_i && (state_q == ST_PARAM) && (got_q + 3'h1 == need_q);
  wire logic exec_now = (take_code && (param_count == 3'h0)) || last_param;
  wire logic [7:0] exec_code = take_code ? byte_i : code_q;
  wire logic [7:0] last_byte = byte_i;

  wire logic med_ok = in_range(p0_q, `ROW_MAX) && in_range(p1_q, `COL_MAX) &&
                      (last_byte <= `DIGIT_MAX) && (bank_q == graph_digit_pkg::BANK_MEDIUM);
  wire logic hbar_ok = in_range(p0_q, `HCOL_MAX) && in_range(p1_q, `HROW_MAX) &&
                       (p2_q <= 8'h01) && (last_byte <= `HLEN_MAX) &&
                       (bank_q == graph_digit_pkg::BANK_HBAR);
  wire logic vbar_ok = in_range(p0_q, `HCOL_MAX) && (last_byte <= `VLEN_MAX) &&
                       (bank_q == graph_digit_pkg::BANK_VBAR);
  wire logic out_sel_ok = (last_byte >= 8'h01) && (last_byte <= 8'(OUT_COUNT));
  wire logic [7:0] out_index = last_byte - 8'h01;

  // one compare per output bit keeps a variable index out of the set and clear paths
  wire logic [OUT_COUNT-1:0] out_hit;
  generate
    for (genvar k = 0; k < OUT_COUNT; k++) begin : g_out_hit
      assign out_hit[k] = out_sel_ok && (out_index == 8'(k));
    end
  endgenerate
  // start-up states win over an output command ending in the same cycle; that command is lost
  wire logic boot_apply = !boot_done_q && nv_ready_i;
  wire logic out_on_now = exec_now && (exec_code == `CMD_OUT_ON);
  wire logic out_off_now = exec_now && (exec_code == `CMD_OUT_OFF);
  wire logic boot_store_now = exec_now && (exec_code == `CMD_OUT_BOOT) &&
                              (last_byte <= 8'h01);

  always_comb begin
    state_d = state_q;
    if (byte_valid_i) begin
      case (state_q)
        ST_PREFIX: state_d = (byte_i == `CMD_PREFIX) ? ST_CODE : ST_PREFIX;
        // an unknown code drops the frame; bytes it would have carried are read as idle
        ST_CODE: state_d = (code_known && param_count != 3'h0) ? ST_PARAM : ST_PREFIX;
        ST_PARAM: state_d = last_param ? ST_PREFIX : ST_PARAM;
        default: state_d = ST_PREFIX;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_PREFIX;
      code_q <= 8'h00;
      need_q <= 3'h0;
      got_q <= 3'h0;
      p0_q <= 8'h00;
      p1_q <= 8'h00;
      p2_q <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // busy_o comes from its own flop; it always equals state_q != ST_PREFIX
      busy_q <= (state_d != ST_PREFIX);
      if (take_code) begin
        code_q <= byte_i;
        need_q <= param_count;
        got_q <= 3'h0;
      end else if (byte_valid_i && state_q == ST_PARAM) begin
        got_q <= got_q + 3'h1;
        case (got_q)
          3'h0: p0_q <= byte_i;
          3'h1: p1_q <= byte_i;
          3'h2: p2_q <= byte_i;
          default: p2_q <= p2_q;
        endcase
      end
    end
  end

  // character bank selection; a new bank replaces the old as active memory
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bank_q <= graph_digit_pkg::BANK_NONE;
      bar_width_q <= 8'h00;
      bank_load_q <= 1'b0;
    end else begin
      bank_load_q <= 1'b0;
      if (exec_now) begin
        case (exec_code)
          `CMD_MED_INIT: begin
            bank_q <= graph_digit_pkg::BANK_MEDIUM;
            bank_load_q <= 1'b1;
          end
          `CMD_HBAR_INIT: begin
            bank_q <= graph_digit_pkg::BANK_HBAR;
            bank_load_q <= 1'b1;
          end
          `CMD_NBAR_INIT: begin
            bank_q <= graph_digit_pkg::BANK_VBAR;
            bar_width_q <= `NARROW_BAR_PX;
            bank_load_q <= 1'b1;
          end
          `CMD_WBAR_INIT: begin
            bank_q <= graph_digit_pkg::BANK_VBAR;
            bar_width_q <= `WIDE_BAR_PX;
            bank_load_q <= 1'b1;
          end
          default: bank_load_q <= 1'b0;
        endcase
      end
    end
  end

  // draw requests; out of range or missing bank raise draw_error_o and draw nothing
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      draw_q <= graph_digit_pkg::DRAW_NONE;
      draw_valid_q <= 1'b0;
      draw_col_q <= 8'h00;
      draw_row_q <= 8'h00;
      draw_value_q <= 8'h00;
      draw_left_q <= 1'b0;
      draw_error_q <= 1'b0;
    end else begin
      draw_valid_q <= 1'b0;
      draw_error_q <= 1'b0;
      if (exec_now) begin
        case (exec_code)
          `CMD_MED_PLACE: begin
            draw_q <= graph_digit_pkg::DRAW_DIGIT;
            draw_row_q <= p0_q;
            draw_col_q <= p1_q;
            draw_value_q <= last_byte;
            draw_left_q <= 1'b0;
            draw_valid_q <= med_ok;
            draw_error_q <= !med_ok;
          end
          `CMD_HBAR_PLACE: begin
            draw_q <= graph_digit_pkg::DRAW_HBAR;
            draw_col_q <= p0_q;
            draw_row_q <= p1_q;
            draw_left_q <= p2_q[0];
            draw_value_q <= last_byte;
            draw_valid_q <= hbar_ok;
            draw_error_q <= !hbar_ok;
          end
          `CMD_VBAR_PLACE: begin
            draw_q <= graph_digit_pkg::DRAW_VBAR;
            draw_col_q <= p0_q;
            draw_row_q <= 8'h01;
            draw_left_q <= 1'b0;
            draw_value_q <= last_byte;
            draw_valid_q <= vbar_ok;
            draw_error_q <= !vbar_ok;
          end
          default: draw_valid_q <= 1'b0;
        endcase
      end
    end
  end

  // switched outputs; start-up states are applied once when non-volatile memory is ready
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_q <= '0;
      boot_done_q <= 1'b0;
      nv_write_q <= 1'b0;
      nv_number_q <= 8'h00;
      nv_state_q <= 1'b0;
    end else begin
      nv_write_q <= 1'b0;
      if (boot_apply) begin
        out_q <= nv_out_state_i;
        boot_done_q <= 1'b1;
      end else if (out_on_now) begin
        out_q <= out_q | out_hit;
      end else if (out_off_now) begin
        out_q <= out_q & ~out_hit;
      end
      // stored only; the live output changes at the next power-up
      if (boot_store_now) begin
        nv_write_q <= 1'b1;
        nv_number_q <= p0_q;
        nv_state_q <= last_byte[0];
      end
    end
  end

  assign bank_o = bank_q;
  assign bar_width_o = bar_width_q;
  assign bank_load_o = bank_load_q;
  assign draw_o = draw_q;
  assign draw_valid_o = draw_valid_q;
  assign draw_col_o = draw_col_q;
  assign draw_row_o = draw_row_q;
  assign draw_value_o = draw_value_q;
  assign draw_left_o = draw_left_q;
  assign draw_error_o = draw_error_q;
  assign switched_output_o = out_q;
  assign nv_write_o = nv_write_q;
  assign nv_number_o = nv_number_q;
  assign nv_state_o = nv_state_q;
  assign busy_o = busy_q;
endmodule // graph_digit_cmd

// ---- tb/graph_digit_assertions.sv ----
// port checker for the graph and digit decoder
// assumes the constants header is on the include path
`timescale 1ns/10ps
`include "graph_digit_consts.svh"
module graph_digit_assertions (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // command bytes
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  // bank and draw results
  input wire graph_digit_pkg::bank_t bank_o,
  input wire logic [7:0] bar_width_o,
  input wire logic bank_load_o,
  input wire graph_digit_pkg::draw_t draw_o,
  input wire logic draw_valid_o,
  input wire logic [7:0] draw_col_o,
  input wire logic [7:0] draw_row_o,
  input wire logic [7:0] draw_value_o,
  // store request and state
  input wire logic nv_write_o,
  input wire logic nv_state_o,
  input wire logic busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_pre;
    byte_valid_i && byte_i == `CMD_PREFIX && !busy_o;
  endsequence
  sequence s_cmd(logic [7:0] code);
    s_pre ##1 byte_valid_i && byte_i == code;
  endsequence
  prefix_busy_a: assert property (s_pre |=> busy_o)
    else $error("prefix not taken");
  med_init_a: assert property (s_cmd(`CMD_MED_INIT) |=> bank_load_o &&
    bank_o == graph_digit_pkg::BANK_MEDIUM) else $error("medium bank not loaded");
  hbar_init_a: assert property (s_cmd(`CMD_HBAR_INIT) |=> bank_load_o &&
    bank_o == graph_digit_pkg::BANK_HBAR) else $error("hbar bank not loaded");
  narrow_init_a: assert property (s_cmd(`CMD_NBAR_INIT) |=> bank_load_o &&
    bar_width_o == `NARROW_BAR_PX) else $error("narrow width wrong");
  wide_init_a: assert property (s_cmd(`CMD_WBAR_INIT) |=> bank_load_o &&
    bar_width_o == `WIDE_BAR_PX) else $error("wide width wrong");
  digit_range_a: assert property (draw_valid_o && draw_o == graph_digit_pkg::DRAW_DIGIT |->
    draw_row_o >= 1 && draw_row_o <= `ROW_MAX && draw_col_o >= 1 && draw_col_o <= `COL_MAX
    && draw_value_o <= `DIGIT_MAX) else $error("digit out of range");
  hbar_range_a: assert property (draw_valid_o && draw_o == graph_digit_pkg::DRAW_HBAR |->
    draw_col_o >= 1 && draw_col_o <= `HCOL_MAX && draw_row_o >= 1 && draw_row_o <= `HROW_MAX
    && draw_value_o <= `HLEN_MAX) else $error("hbar out of range");
  vbar_range_a: assert property (draw_valid_o && draw_o == graph_digit_pkg::DRAW_VBAR |->
    draw_col_o >= 1 && draw_col_o <= `HCOL_MAX && draw_row_o == 8'h01
    && draw_value_o <= `VLEN_MAX) else $error("vbar out of range");
  nv_state_a: assert property (nv_write_o |-> $past(byte_valid_i) &&
    $past(byte_i) == {7'h00, nv_state_o}) else $error("stored state wrong");
endmodule // graph_digit_assertions
bind graph_digit_cmd graph_digit_assertions u_graph_digit_assertions (.*);

// ---- tb/host_model.sv ----
// host side: sends queued command bytes back to back
// assumes the bench queues whole commands after reset
`timescale 1ns/10ps
module host_model (
  // clock
  input wire logic clk_i,
  // byte stream
  output logic byte_valid_o,
  output logic [7:0] byte_o
);
  logic [7:0] q[$];
  initial byte_valid_o = 1'b0;
  initial byte_o = 8'h00;
  always @(posedge clk_i) begin
    if (q.size() != 0) begin
      byte_valid_o <= 1'b1;
      byte_o <= q.pop_front();
    end else begin
      byte_valid_o <= 1'b0;
      // idle data toggles so a stale byte never looks valid
      byte_o <= ~byte_o;
    end
  end
endmodule // host_model

// ---- tb/tb.sv ----
// bench for the graph and digit decoder: random and corner commands
// assumes design files, host_model and the checker compile first
`timescale 1ns/10ps
module tb;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic nv_ready_i = 1'b0;
  logic [7:0] nv_out_state_i = 8'h00;
  logic byte_valid_i;
  logic [7:0] byte_i;
  graph_digit_pkg::bank_t bank_o;
  graph_digit_pkg::draw_t draw_o;
  logic [7:0] bar_width_o, draw_col_o, draw_row_o, draw_value_o;
  logic [7:0] nv_number_o, switched_output_o, c, r, d, l, sw;
  logic bank_load_o, draw_valid_o, draw_left_o, draw_error_o;
  logic nv_write_o, nv_state_o, busy_o;
  logic [3:0] ev = 4'h0;
  bit ok;
  int err_total = 0;
  int n_tests = 0;
  always #5 clk_i = ~clk_i;
  host_model u_host_model (.clk_i(clk_i), .byte_valid_o(byte_valid_i), .byte_o(byte_i));
  graph_digit_cmd u_graph_digit_cmd (.*);
  // pulses last one cycle, so they are gathered per command
  always @(posedge clk_i) ev <= ev | {nv_write_o, bank_load_o, draw_error_o, draw_valid_o};
  function automatic bit in_r(input logic [7:0] v, input int lo, input int hi);
    return v >= lo && v <= hi;
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic run(input logic [7:0] b[$]);
    int k;
    @(negedge clk_i);
    ev = 4'h0;
    foreach (b[i]) u_host_model.q.push_back(b[i]);
    k = 0;
    while (u_host_model.q.size() != 0 && k < 50) begin
      @(posedge clk_i);
      k++;
    end
    if (u_host_model.q.size() != 0) err_total++;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic pl(input logic [7:0] b[$], input bit g, input logic [7:0] k, cl, rw, v,
                    input logic lf);
    run(b);
    chk("draw_valid", 8'(g), 8'(ev[0]));
    chk("draw_error", 8'(!g), 8'(ev[1]));
    if (g) begin
      chk("draw_kind", k, 8'(draw_o));
      chk("draw_col", cl, draw_col_o);
      chk("draw_row", rw, draw_row_o);
      chk("draw_value", v, draw_value_o);
      if (k == 8'h02) chk("draw_left", 8'(lf), 8'(draw_left_o));
    end
  endtask
  task automatic finish_test;
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    finish_test;
  end
  initial begin
    void'($urandom(34));
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    sw = 8'($urandom);
    @(posedge clk_i);
    #1;
    chk("sw_before_boot", 8'h00, switched_output_o);
    @(posedge clk_i);
    nv_out_state_i <= sw;
    nv_ready_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk("sw_boot", sw, switched_output_o);
    pl({8'hfe, 8'h6f, 8'h02, 8'h03, 8'h07}, 0, 0, 0, 0, 0, 0);
    run({8'hfe, 8'h6d});
    chk("bank_medium", 8'(graph_digit_pkg::BANK_MEDIUM), 8'(bank_o));
    chk("bank_load_med", 8'h01, 8'(ev[2]));
    for (int i = 0; i < 8; i++) begin
      r = (i == 0) ? 8'h14 : 8'($urandom % 23);
      c = (i == 0) ? 8'h04 : 8'($urandom % 6);
      d = 8'($urandom % 12);
      ok = in_r(r, 1, 20) && in_r(c, 1, 4) && d <= 9;
      pl({8'hfe, 8'h6f, r, c, d}, ok, 8'h01, c, r, d, 0);
    end
    run({8'hfe, 8'h68});
    chk("bank_hbar", 8'(graph_digit_pkg::BANK_HBAR), 8'(bank_o));
    chk("bank_load_hbar", 8'h01, 8'(ev[2]));
    pl({8'hfe, 8'h3d, 8'h01, 8'h05}, 0, 0, 0, 0, 0, 0);
    for (int i = 0; i < 10; i++) begin
      c = (i == 0) ? 8'h14 : 8'($urandom % 22);
      r = (i == 0) ? 8'h04 : 8'($urandom % 6);
      d = (i == 0) ? 8'h01 : 8'($urandom % 3);
      l = (i == 0) ? 8'h64 : 8'($urandom % 104);
      ok = in_r(c, 1, 20) && in_r(r, 1, 4) && d <= 1 && l <= 100;
      pl({8'hfe, 8'h7c, c, r, d, l}, ok, 8'h02, c, r, l, d[0]);
    end
    run({8'hfe, 8'h73});
    chk("narrow_width", 8'h02, bar_width_o);
    chk("bank_load_narrow", 8'h01, 8'(ev[2]));
    run({8'hfe, 8'h76});
    chk("wide_width", 8'h05, bar_width_o);
    chk("bank_vbar", 8'(graph_digit_pkg::BANK_VBAR), 8'(bank_o));
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? 8'h14 : 8'($urandom % 22);
      l = (i == 0) ? 8'h20 : 8'($urandom % 35);
      ok = in_r(c, 1, 20) && l <= 32;
      pl({8'hfe, 8'h3d, c, l}, ok, 8'h03, c, 8'h01, l, 0);
    end
    run({8'hfe, 8'h00, 8'hfe, 8'h57, 8'h01});
    sw[0] = 1'b1;
    chk("sw_after_unknown", sw, switched_output_o);
    for (int i = 0; i < 10; i++) begin
      c = 8'($urandom % 10);
      d = 8'($urandom % 2);
      run({8'hfe, d[0] ? 8'h57 : 8'h56, c});
      if (in_r(c, 1, 8)) sw[c-1] = d[0];
      chk("sw_cmd", sw, switched_output_o);
    end
    for (int i = 0; i < 6; i++) begin
      c = 8'($urandom % 8 + 1);
      d = 8'($urandom % 3);
      run({8'hfe, 8'hc3, c, d});
      chk("nv_write", 8'(d <= 1), 8'(ev[3]));
      if (d <= 1) chk("nv_number", c, nv_number_o);
      if (d <= 1) chk("nv_state", d, 8'(nv_state_o));
      chk("sw_kept", sw, switched_output_o);
    end
    finish_test;
  end
endmodule // tb
